/* shared/bpm_pkg.sv */
/*
 * Package of the pack protection and power-mode supervisor: register map,
 * reset values, field positions, timing counts, state and carrier types.
 * Assumes a 20 MHz system clock and an AHB-Lite register bus of 32-bit words.
 */
package bpm_pkg;
    // Timing: the slow time base is one millisecond.
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [15:0] NORMAL_PERIOD_MS = 16'h03E8;
    localparam logic [15:0] LED_HOLD_MS = 16'h0FA0;

    // Voltage limits in millivolts.
    localparam logic [15:0] DEEP_UV_LIMIT_MV = 16'h0A8C;
    localparam logic [15:0] DEEP_UV_RST = 16'h09C4;
    localparam logic [15:0] RECOVER_RST = 16'h0A8C;

    // Register reset values.
    localparam logic [6:0] CTRL_RST = 7'h54;
    localparam logic [15:0] IDLE_RST = 16'h2710;
    localparam logic [15:0] STBY_PERIOD_RST = 16'h2710;
    localparam logic [15:0] SHIP_PERIOD_RST = 16'hEA60;
    localparam logic [31:0] DLY_RST = 32'h0A0A0A0A;
    localparam logic [15:0] ZERO_SNAP_RST = 16'h0003;

    // Byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DEEP_UV = 8'h08;
    localparam logic [7:0] ADDR_RECOVER = 8'h0C;
    localparam logic [7:0] ADDR_IDLE = 8'h10;
    localparam logic [7:0] ADDR_STBY_PERIOD = 8'h14;
    localparam logic [7:0] ADDR_SHIP_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_DLY1_A = 8'h1C;
    localparam logic [7:0] ADDR_DLY1_B = 8'h20;
    localparam logic [7:0] ADDR_DLY2 = 8'h24;
    localparam logic [7:0] ADDR_ZERO_SNAP = 8'h28;
    localparam logic [7:0] ADDR_CHARGE_ACC = 8'h2C;
    localparam logic [7:0] ADDR_LOG_INFO = 8'h30;
    localparam logic [7:0] ADDR_LOG_BASE = 8'h40;

    // Control register fields.
    localparam int CTRL_POL_LSB = 0;
    localparam int CTRL_EXT_EN = 2;
    localparam int CTRL_DOT = 3;
    localparam int CTRL_LEDN_LSB = 4;

    // Sizes.
    localparam int NUM_L1 = 8;
    localparam int NUM_L2 = 4;
    localparam int LOG_DEPTH = 10;
    localparam int ACC_W = 18;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_STANDBY,
        ST_SHIP,
        ST_DEEP_CELL_UNDERVOLT_SHUTDOWN
    } bpm_state_e;

    typedef struct packed {
        logic pre;
        logic chg;
        logic dsg;
    } bpm_fets_s;

    typedef struct packed {
        logic [11:0] temp;
        logic [15:0] mv;
    } bpm_env_s;
endpackage

/* sim/bpm_fet_model.sv */
/* Pack switch model: sense pins follow the gates one clock late.
   Assumes stuck is raised by the bench to weld the switches closed. */
`timescale 1ns/100ps
`default_nettype none
module bpm_fet_model (
    input wire logic clk,
    input wire bpm_pkg::bpm_fets_s fet,
    input wire logic stuck,
    output logic chg_sense,
    output logic dsg_sense
);
    always_ff @(posedge clk) begin
        chg_sense <= fet.chg || stuck;
        dsg_sense <= fet.dsg || stuck;
    end
endmodule
`default_nettype wire

/* sim/bpm_props.sv */
/* Port checker of the supervisor.
   Assumes binding to bpm_top with the same tick parameter. */
`timescale 1ns/100ps
`default_nettype none
module bpm_props
import bpm_pkg::*;
#(parameter int TICK_CYCLES = bpm_pkg::TICK_CYCLES) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [bpm_pkg::NUM_L1-1:0] FAULT_IN,
    input wire logic SMB_CLK_IN,
    input wire logic SMB_DAT_IN,
    input wire bpm_pkg::bpm_fets_s FET_ON,
    input wire logic FUSE_BLOW,
    input wire logic MEAS_TRIGGER,
    input wire bpm_pkg::bpm_state_e POWER_STATE
);
    logic [15:0] trip_cnt_r;
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || FAULT_IN == 0 || POWER_STATE != ST_ACTIVE) begin
            trip_cnt_r <= 16'h0000;
        end else if (trip_cnt_r != 16'hFFFF) begin
            trip_cnt_r <= trip_cnt_r + 16'h0001;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    fuse_hold_a: assert property (FUSE_BLOW |=> FUSE_BLOW)
        else $error("fuse released");
    fuse_fets_a: assert property (FUSE_BLOW |=> FET_ON == 3'h0)
        else $error("switches on with fuse");
    ship_fets_a: assert property (POWER_STATE == ST_SHIP ##1 POWER_STATE == ST_SHIP |-> FET_ON == 3'h0)
        else $error("switches on in ship");
    ship_exit_a: assert property (POWER_STATE == ST_SHIP && (SMB_CLK_IN || SMB_DAT_IN) |-> ##[1:4] POWER_STATE != ST_SHIP)
        else $error("ship not left");
    ship_entry_a: assert property (POWER_STATE != ST_SHIP ##1 POWER_STATE == ST_SHIP |-> $past(SMB_CLK_IN || SMB_DAT_IN, 3) == 1'b0)
        else $error("ship with bus high");
    deep_fets_a: assert property (POWER_STATE == ST_DEEP_CELL_UNDERVOLT_SHUTDOWN [*2] |-> !FET_ON.chg && !FET_ON.dsg)
        else $error("switches on in deep undervolt");
    trip_open_a: assert property (trip_cnt_r > 11 * TICK_CYCLES + 4 |-> !FET_ON.chg && !FET_ON.dsg)
        else $error("fault did not open");
    meas_pulse_a: assert property (MEAS_TRIGGER |=> !MEAS_TRIGGER)
        else $error("trigger too long");
    cover property (POWER_STATE == ST_SHIP);
    cover property (POWER_STATE == ST_DEEP_CELL_UNDERVOLT_SHUTDOWN);
    cover property ($rose(FUSE_BLOW));
endmodule
bind bpm_top bpm_props #(.TICK_CYCLES(TICK_CYCLES)) bpm_props_i (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .FAULT_IN(FAULT_IN), .SMB_CLK_IN(SMB_CLK_IN), .SMB_DAT_IN(SMB_DAT_IN), .FET_ON(FET_ON),
    .FUSE_BLOW(FUSE_BLOW), .MEAS_TRIGGER(MEAS_TRIGGER), .POWER_STATE(POWER_STATE));
`default_nettype wire

/* sim/bpm_top_tb.sv */
/* Bench of the supervisor: registers, trips, ship, deep undervolt, fuse.
   Assumes a 50 ns clock and a ten-clock tick. */
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
`define WT(c, n) begin wt = 0; while (!(c) && wt < n) begin @(posedge clk); #1; wt++; end end
module bpm_top_tb;
import bpm_pkg::*;
logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, ship = 0, smbc = 1, smbd = 1;
logic btn = 0, chgr = 0, stuck = 0, load = 1, cv = 0, hrdy, hresp, fuse, meas, envs, chs, dss;
logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
logic [1:0] htrans = 0, ext = 0;
logic [2:0] sec = 0;
logic [7:0] fault = 0;
logic [15:0] mv = 16'h0E74;
logic [4:0] led;
bpm_fets_s fet;
bpm_env_s envd;
bpm_state_e st;
int err_count = 0, check_count = 0, wt;
always #25 clk = ~clk;
bpm_top #(.TICK_CYCLES(10)) bpm_top_i (.SYS_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .MIN_CELL_MV(mv), .MAX_CELL_MV(mv),
    .TEMP_CODE(12'h190), .LOAD_ACTIVE(load), .FAULT_IN(fault), .SEC_FAULT_IN(sec),
    .SHIP_CMD(ship), .SMB_CLK_IN(smbc), .SMB_DAT_IN(smbd), .EXTERNAL_SWITCH_CONTROL_INPUT(ext),
    .DISPLAY_REQUEST_BUTTON(btn), .CHARGER_PRESENT(chgr), .CHG_FET_SENSE(chs),
    .DSG_FET_SENSE(dss), .CURRENT_SAMPLE(16'sh0000), .CURRENT_VALID(cv), .SOC_PCT(7'h64),
    .FET_ON(fet), .FUSE_BLOW(fuse), .LED_N(led), .MEAS_TRIGGER(meas), .ENV_LOG_STROBE(envs),
    .ENV_LOG_DATA(envd), .POWER_STATE(st));
bpm_fet_model bpm_fet_model_i (.clk(clk), .fet(fet), .stuck(stuck), .chg_sense(chs),
    .dsg_sense(dss));
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
endtask
task t_regs;
    bus(0, ADDR_CTRL, 0); `CK("ctrl", 32'h54, rd)
    bus(1, ADDR_DEEP_UV, 32'h0BB8); bus(0, ADDR_DEEP_UV, 0);
    `CK("deep_uv", {16'h0, DEEP_UV_LIMIT_MV - 16'h1}, rd)
    bus(0, 8'h3C, 0); `CK("unmapped", 32'h0, rd)
    cv <= 1; bus(0, ADDR_CHARGE_ACC, 0); `CK("acc", 32'h0, rd)
    bus(1, ADDR_DEEP_UV, {16'h0, DEEP_UV_RST}); bus(1, ADDR_SHIP_PERIOD, 32'h5);
    btn <= 1'b1; `WT(led !== 5'h1F, 20) `CK("leds", 5'h00, led)
    bus(1, ADDR_IDLE, 32'h3); load <= 0; `WT(st == ST_STANDBY, 60) load <= 1;
    `CK("standby", ST_STANDBY, st) `WT(st == ST_ACTIVE, 5) `CK("wake", ST_ACTIVE, st)
endtask
task t_trip;
    fault <= 8'h80; `WT(!fet.dsg, 400) `CK("trip", 2'b00, {fet.chg, fet.dsg})
    fault <= 8'h00; bus(0, ADDR_LOG_INFO, 0); `CK("log", 4'h1, rd[7:4])
    ext <= 2'h2; `WT(!fet.dsg, 9) `CK("ext", 1'b0, fet.dsg)
    ext <= 0; `WT(fet.dsg, 100)
endtask
task t_ship;
    smbc <= 0; smbd <= 0; repeat (10) @(posedge clk); #1 `CK("no cmd", ST_ACTIVE, st)
    smbc <= 1; smbd <= 1; repeat (4) @(posedge clk);
    ship <= 1; @(posedge clk); ship <= 0; smbc <= 0; smbd <= 0;
    `WT(st == ST_SHIP, 20) `CK("ship", ST_SHIP, st)
    @(posedge clk); #1 `CK("ship fets", 3'h0, fet)
    `WT(envs, 80) `CK("env", {12'h190, 16'h0E74}, envd)
    smbd <= 1; `WT(st != ST_SHIP, 10) `CK("ship exit", ST_ACTIVE, st)
    smbc <= 1;
endtask
task t_deep;
    chgr <= 1; mv <= 16'h0960; `WT(st == ST_DEEP_CELL_UNDERVOLT_SHUTDOWN, 12000)
    `CK("deep", ST_DEEP_CELL_UNDERVOLT_SHUTDOWN, st)
    `WT(fet == 3'h4, 20) `CK("deep fets", 3'h4, fet)
    mv <= 16'h0A28; repeat (200) @(posedge clk); #1
    `CK("deep hold", ST_DEEP_CELL_UNDERVOLT_SHUTDOWN, st)
    mv <= 16'h0AF0; `WT(st == ST_ACTIVE, 12000) `CK("recover", ST_ACTIVE, st)
    chgr <= 0;
endtask
task t_fuse;
    stuck <= 1; fault <= 8'h01; `WT(fuse, 1000) `CK("fuse", 1'b1, fuse)
    fault <= 0; stuck <= 0; repeat (50) @(posedge clk); #1 `CK("fuse held", 1'b1, fuse)
    `CK("fuse fets", 3'h0, fet)
endtask
task wrap_up;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask
initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs; t_trip; t_ship; t_deep; t_fuse; wrap_up;
end
initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    wrap_up;
end
endmodule
`default_nettype wire

/* src/bpm_qual.sv */
/*
 * Delay qualifier for one safety trigger: the output rises after the raw
 * condition has stood for the programmed number of millisecond ticks.
 * Assumes tick is a one-cycle enable pulse on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module bpm_qual #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic raw,
    input wire logic [W-1:0] dly,
    output logic q
);
    logic [W-1:0] cnt_r;

    // A raw drop clears both the count and the output at once.
    always_ff @(posedge clk) begin
        if (!nrst || !raw) begin
            cnt_r <= '0;
            q <= 1'b0;
        end else begin
            if (tick && cnt_r < dly) begin
                cnt_r <= cnt_r + 1'b1;
            end
            q <= (cnt_r >= dly);
        end
    end
endmodule
`default_nettype wire

/* src/bpm_sync.sv */
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous levels; the output is on SYS_CLK.
 */
`timescale 1ns/100ps
`default_nettype none
module bpm_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* src/bpm_top.sv */
/*
 * Protection and power-mode supervisor of a 3 or 4 cell pack: power states,
 * first-level switch control, second-level fuse, external switch inputs,
 * display, charge accumulator, failure log and AHB-Lite registers.
 * Assumes converter results and fault flags arrive on SYS_CLK; pins are
 * synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
// Contract
// (R01) Active state measures, decides and updates about once per second, safety on.
// (R02) Standby behaves like active with full safety but measures less often.
// (R03) Go standby after configured idle time without load; return on load.
// (R04) Ship opens all switches, disables safety, monitors at a reduced rate.
// (R05) Ship entered only after the ship command, then both bus lines low.
// (R06) Ship is left once either bus line goes high.
// (R07) In ship, environmental measurements are handed to flash storage.
// (R08) Deep undervolt entered below a threshold settable only under 2.7 V.
// (R09) Deep undervolt opens charge and discharge; pre-charge on with charger.
// (R10) Deep undervolt left when cells rise above the recovery threshold.
// (R11) Over-current detection active in active and standby only.
// (R12) Listed cell, pack, current and short faults open the switches.
// (R13) Switches failing to open when commanded blow the fuse; code checks charge and discharge in active and standby only.
// (R14) Second-level detection and fuse are independent of first-level logic.
// (R15) Every first- and second-level trigger has its own programmable delay.
// (R16) External switch inputs sampled with programmable polarity drive switches.
// (R17) Push-button request shows charge state on three to five LEDs.
// (R18) Charge accumulator integrates both directions, 18 bits, with deadband.
// (R19) Last ten first-level failures are logged and readable over the bus.
// (R20) Fuse output stays asserted until reset.
module bpm_top #(
    parameter int TICK_CYCLES = bpm_pkg::TICK_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [15:0] MIN_CELL_MV,
    input wire logic [15:0] MAX_CELL_MV,
    input wire logic [11:0] TEMP_CODE,
    input wire logic LOAD_ACTIVE,
    input wire logic [bpm_pkg::NUM_L1-1:0] FAULT_IN,
    input wire logic [bpm_pkg::NUM_L2-2:0] SEC_FAULT_IN,
    input wire logic SHIP_CMD,
    input wire logic SMB_CLK_IN,
    input wire logic SMB_DAT_IN,
    input wire logic [1:0] EXTERNAL_SWITCH_CONTROL_INPUT,
    input wire logic DISPLAY_REQUEST_BUTTON,
    input wire logic CHARGER_PRESENT,
    input wire logic CHG_FET_SENSE,
    input wire logic DSG_FET_SENSE,
    input wire logic signed [15:0] CURRENT_SAMPLE,
    input wire logic CURRENT_VALID,
    input wire logic [6:0] SOC_PCT,
    output bpm_pkg::bpm_fets_s FET_ON,
    output logic FUSE_BLOW,
    output logic [4:0] LED_N,
    output logic MEAS_TRIGGER,
    output logic ENV_LOG_STROBE,
    output bpm_pkg::bpm_env_s ENV_LOG_DATA,
    output bpm_pkg::bpm_state_e POWER_STATE
);
    import bpm_pkg::*;

    if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES must lie between 2 and 65536");
    end

    function automatic logic [3:0] log_index(input logic [7:0] a);
        log_index = 4'((a - ADDR_LOG_BASE) >> 2);
    endfunction

    // Pin synchronisation.
    logic [7:0] pins_sync;
    logic smb_clk;
    logic smb_dat;
    logic [1:0] ext_in;
    logic btn;
    logic charger;
    logic chg_sense;
    logic dsg_sense;

    bpm_sync #(.W(8)) u_sync (
        .clk(SYS_CLK),
        .nrst(NRST),
        .d({SMB_CLK_IN, SMB_DAT_IN, EXTERNAL_SWITCH_CONTROL_INPUT, DISPLAY_REQUEST_BUTTON,
            CHARGER_PRESENT, CHG_FET_SENSE, DSG_FET_SENSE}),
        .q(pins_sync)
    );
    assign {smb_clk, smb_dat, ext_in, btn, charger, chg_sense, dsg_sense} = pins_sync;

    // Registers.
    logic [6:0] ctrl_r;
    logic [15:0] deep_uv_r;
    logic [15:0] recover_r;
    logic [15:0] idle_r;
    logic [15:0] stby_period_r;
    logic [15:0] ship_period_r;
    logic [31:0] dly1a_r;
    logic [31:0] dly1b_r;
    logic [31:0] dly2_r;
    logic [15:0] zero_snap_r;
    logic signed [ACC_W-1:0] acc_r;
    bpm_state_e state_r;
    bpm_state_e state_nxt;
    bpm_fets_s fet_r;
    bpm_fets_s fet_nxt;
    logic fuse_r;
    logic ship_armed_r;
    logic [15:0] tick_cnt_r;
    logic tick_ms;
    logic [15:0] idle_cnt_r;
    logic [15:0] meas_cnt_r;
    logic [15:0] period;
    logic meas_r;
    logic env_strobe_r;
    bpm_env_s env_data_r;
    logic [15:0] led_timer_r;
    logic btn_d_r;
    logic [4:0] led_n_r;
    logic [15:0] log_mem_r [LOG_DEPTH];
    logic [3:0] log_ptr_r;
    logic [3:0] log_cnt_r;
    logic [7:0] log_seq_r;
    logic trip_d_r;

    // AHB-Lite slave: address phase captured, read data registered for data phase.
    logic dph_valid_r;
    logic dph_write_r;
    logic [7:0] dph_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_nxt;
    logic aph;
    logic wr_en;

    assign aph = HSEL && HTRANS[1] && HREADY;
    assign wr_en = dph_valid_r && dph_write_r;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_r;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            dph_valid_r <= 1'b0;
            dph_write_r <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            dph_valid_r <= aph;
            dph_write_r <= aph && HWRITE;
            if (aph) begin
                dph_addr_r <= HADDR[7:0];
                hrdata_r <= HWRITE ? 32'h00000000 : rd_nxt;
            end
        end
    end

    // Safety enables and qualified triggers.
    logic safety_on;
    logic [NUM_L1-1:0] l1_raw;
    logic [NUM_L1-1:0] l1_q;
    logic [NUM_L2-1:0] l2_raw;
    logic [NUM_L2-1:0] l2_q;
    logic [63:0] dly1;
    logic fet_fail;
    logic trip;
    logic [1:0] ext_off;
    logic display;

    assign safety_on = (state_r == ST_ACTIVE) || (state_r == ST_STANDBY); // [R02] [R04] [R11]
    assign l1_raw = FAULT_IN & {NUM_L1{safety_on}}; // [R11] [R12]
    assign fet_fail = (!fet_r.chg && chg_sense) || (!fet_r.dsg && dsg_sense); // [R13]
    assign l2_raw = {SEC_FAULT_IN, fet_fail} & {NUM_L2{safety_on}}; // [R14]
    assign dly1 = {dly1b_r, dly1a_r};
    assign trip = |l1_q; // [R12]
    assign ext_off = (ext_in ^ ctrl_r[CTRL_POL_LSB +: 2]) & {2{ctrl_r[CTRL_EXT_EN]}}; // [R16]
    assign display = (led_timer_r != 16'h0000);

    for (genvar i = 0; i < NUM_L1; i++) begin : g_l1
        bpm_qual #(.W(8)) u_q1 ( // [R15]
            .clk(SYS_CLK),
            .nrst(NRST),
            .tick(tick_ms),
            .raw(l1_raw[i]),
            .dly(dly1[8*i +: 8]),
            .q(l1_q[i])
        );
    end
    for (genvar j = 0; j < NUM_L2; j++) begin : g_l2
        bpm_qual #(.W(8)) u_q2 ( // [R15] [R14]
            .clk(SYS_CLK),
            .nrst(NRST),
            .tick(tick_ms),
            .raw(l2_raw[j]),
            .dly(dly2_r[8*j +: 8]),
            .q(l2_q[j])
        );
    end

    // Register writes; the deep undervolt threshold is clamped below its limit.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_r <= CTRL_RST;
            deep_uv_r <= DEEP_UV_RST;
            recover_r <= RECOVER_RST;
            idle_r <= IDLE_RST;
            stby_period_r <= STBY_PERIOD_RST;
            ship_period_r <= SHIP_PERIOD_RST;
            dly1a_r <= DLY_RST;
            dly1b_r <= DLY_RST;
            dly2_r <= DLY_RST;
            zero_snap_r <= ZERO_SNAP_RST;
        end else if (wr_en) begin
            case (dph_addr_r)
                ADDR_CTRL: ctrl_r <= HWDATA[6:0];
                ADDR_DEEP_UV: begin
                    deep_uv_r <= (HWDATA[15:0] >= DEEP_UV_LIMIT_MV) ?
                        DEEP_UV_LIMIT_MV - 16'h0001 : HWDATA[15:0]; // [R08]
                end
                ADDR_RECOVER: recover_r <= HWDATA[15:0];
                ADDR_IDLE: idle_r <= HWDATA[15:0];
                ADDR_STBY_PERIOD: stby_period_r <= HWDATA[15:0];
                ADDR_SHIP_PERIOD: ship_period_r <= HWDATA[15:0];
                ADDR_DLY1_A: dly1a_r <= HWDATA;
                ADDR_DLY1_B: dly1b_r <= HWDATA;
                ADDR_DLY2: dly2_r <= HWDATA;
                ADDR_ZERO_SNAP: zero_snap_r <= HWDATA[15:0];
                default: ;
            endcase
        end
    end

    // Read decode.
    always_comb begin
        rd_nxt = 32'h00000000;
        case (HADDR[7:0])
            ADDR_CTRL: rd_nxt = {25'h0000000, ctrl_r};
            ADDR_STATUS: rd_nxt = {12'h000, l2_q, l1_q, display, ship_armed_r, fuse_r, fet_r,
                state_r};
            ADDR_DEEP_UV: rd_nxt = {16'h0000, deep_uv_r};
            ADDR_RECOVER: rd_nxt = {16'h0000, recover_r};
            ADDR_IDLE: rd_nxt = {16'h0000, idle_r};
            ADDR_STBY_PERIOD: rd_nxt = {16'h0000, stby_period_r};
            ADDR_SHIP_PERIOD: rd_nxt = {16'h0000, ship_period_r};
            ADDR_DLY1_A: rd_nxt = dly1a_r;
            ADDR_DLY1_B: rd_nxt = dly1b_r;
            ADDR_DLY2: rd_nxt = dly2_r;
            ADDR_ZERO_SNAP: rd_nxt = {16'h0000, zero_snap_r};
            ADDR_CHARGE_ACC: rd_nxt = {{(32-ACC_W){acc_r[ACC_W-1]}}, acc_r};
            ADDR_LOG_INFO: rd_nxt = {16'h0000, log_seq_r, log_cnt_r, log_ptr_r}; // [R19]
            default: begin
                if (HADDR[7:0] >= ADDR_LOG_BASE && HADDR[1:0] == 2'b00 &&
                    log_index(HADDR[7:0]) < 4'(LOG_DEPTH)) begin
                    rd_nxt = {16'h0000, log_mem_r[log_index(HADDR[7:0])]}; // [R19]
                end
            end
        endcase
    end

    // Millisecond time base.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= 16'h0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end
    assign tick_ms = (tick_cnt_r == 16'(TICK_CYCLES - 1));

    // Idle time without load while active.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || LOAD_ACTIVE || state_r != ST_ACTIVE) begin
            idle_cnt_r <= 16'h0000;
        end else if (tick_ms && idle_cnt_r < idle_r) begin
            idle_cnt_r <= idle_cnt_r + 16'h0001; // [R03]
        end
    end

    // Ship command arming; the command is ignored in ship, so the clear on entry always wins.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ship_armed_r <= 1'b0;
        end else if (SHIP_CMD && safety_on) begin
            ship_armed_r <= 1'b1; // [R05]
        end else if (state_r == ST_SHIP) begin
            ship_armed_r <= 1'b0;
        end
    end

    // Power-state sequencing.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_ACTIVE, ST_STANDBY: begin
                if (MIN_CELL_MV < deep_uv_r) begin
                    state_nxt = ST_DEEP_CELL_UNDERVOLT_SHUTDOWN; // [R08]
                end else if (ship_armed_r && !smb_clk && !smb_dat) begin
                    state_nxt = ST_SHIP; // [R05]
                end else if (state_r == ST_STANDBY && LOAD_ACTIVE) begin
                    state_nxt = ST_ACTIVE; // [R03]
                end else if (state_r == ST_ACTIVE && idle_cnt_r >= idle_r && !LOAD_ACTIVE) begin
                    state_nxt = ST_STANDBY; // [R03]
                end
            end
            ST_SHIP: begin
                if (smb_clk || smb_dat) begin
                    state_nxt = ST_ACTIVE; // [R06]
                end
            end
            ST_DEEP_CELL_UNDERVOLT_SHUTDOWN: begin
                if (MIN_CELL_MV > recover_r) begin
                    state_nxt = ST_ACTIVE; // [R10]
                end
            end
            default: state_nxt = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_r <= ST_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign POWER_STATE = state_r;

    // Switch drive from state, first-level trip and external inputs.
    always_comb begin
        fet_nxt = '0;
        case (state_r)
            ST_ACTIVE, ST_STANDBY: begin
                fet_nxt.pre = !trip && !fuse_r; // [R12]
                fet_nxt.chg = !trip && !fuse_r && !ext_off[0]; // [R12] [R16]
                fet_nxt.dsg = !trip && !fuse_r && !ext_off[1]; // [R12] [R16]
            end
            ST_SHIP: fet_nxt = '0; // [R04]
            ST_DEEP_CELL_UNDERVOLT_SHUTDOWN: fet_nxt.pre = charger && !fuse_r; // [R09]
            default: fet_nxt = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            fet_r <= '0;
        end else begin
            fet_r <= fet_nxt;
        end
    end
    assign FET_ON = fet_r;

    // Fuse latches on any qualified second-level trigger.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            fuse_r <= 1'b0;
        end else if (|l2_q) begin
            fuse_r <= 1'b1; // [R13] [R14] [R20]
        end
    end
    assign FUSE_BLOW = fuse_r;

    // Measurement scheduler and ship-mode environmental record.
    always_comb begin
        case (state_r)
            ST_ACTIVE: period = NORMAL_PERIOD_MS; // [R01]
            ST_STANDBY: period = stby_period_r; // [R02]
            default: period = ship_period_r; // [R04]
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST || state_r != state_nxt) begin
            meas_cnt_r <= 16'h0000;
            meas_r <= 1'b0;
        end else begin
            meas_r <= 1'b0;
            if (tick_ms) begin
                if (meas_cnt_r + 16'h0001 >= period) begin
                    meas_cnt_r <= 16'h0000;
                    meas_r <= 1'b1; // [R01] [R02]
                end else begin
                    meas_cnt_r <= meas_cnt_r + 16'h0001;
                end
            end
        end
    end
    assign MEAS_TRIGGER = meas_r;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            env_strobe_r <= 1'b0;
            env_data_r <= '0;
        end else begin
            env_strobe_r <= meas_r && state_r == ST_SHIP; // [R07]
            if (meas_r && state_r == ST_SHIP) begin
                env_data_r <= '{temp: TEMP_CODE, mv: MIN_CELL_MV}; // [R07]
            end
        end
    end
    assign ENV_LOG_STROBE = env_strobe_r;
    assign ENV_LOG_DATA = env_data_r;

    // State-of-charge display.
    logic [2:0] led_n;
    logic [9:0] prod;
    logic [2:0] lit;

    assign led_n = (ctrl_r[CTRL_LEDN_LSB +: 3] < 3'h3) ? 3'h3 :
        (ctrl_r[CTRL_LEDN_LSB +: 3] > 3'h5) ? 3'h5 : ctrl_r[CTRL_LEDN_LSB +: 3];
    assign prod = ((SOC_PCT > 7'h64) ? 10'h064 : {3'h0, SOC_PCT}) * {7'h00, led_n};
    assign lit = 3'((prod + 10'h063) / 10'h064);

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            btn_d_r <= 1'b0;
            led_timer_r <= 16'h0000;
            led_n_r <= 5'h1F;
        end else begin
            btn_d_r <= btn;
            if (btn && !btn_d_r) begin
                led_timer_r <= LED_HOLD_MS; // [R17]
            end else if (tick_ms && display) begin
                led_timer_r <= led_timer_r - 16'h0001;
            end
            for (int k = 0; k < 5; k++) begin
                led_n_r[k] <= !(display && 3'(k) < led_n &&
                    (ctrl_r[CTRL_DOT] ? 3'(k + 1) == lit : 3'(k) < lit)); // [R17]
            end
        end
    end
    assign LED_N = led_n_r;

    // Charge accumulator with zero-snap deadband.
    logic [15:0] mag;

    assign mag = CURRENT_SAMPLE[15] ? 16'(-CURRENT_SAMPLE) : CURRENT_SAMPLE;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            acc_r <= '0;
        end else if (CURRENT_VALID && mag > zero_snap_r) begin
            acc_r <= acc_r + {{(ACC_W-16){CURRENT_SAMPLE[15]}}, CURRENT_SAMPLE}; // [R18]
        end
    end

    // Failure log of the last first-level trips.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            trip_d_r <= 1'b0;
            log_ptr_r <= 4'h0;
            log_cnt_r <= 4'h0;
            log_seq_r <= 8'h00;
            for (int m = 0; m < LOG_DEPTH; m++) begin
                log_mem_r[m] <= 16'h0000;
            end
        end else begin
            trip_d_r <= trip;
            if (trip && !trip_d_r) begin
                log_mem_r[log_ptr_r] <= {log_seq_r, l1_q}; // [R19]
                log_ptr_r <= (log_ptr_r == 4'(LOG_DEPTH - 1)) ? 4'h0 : log_ptr_r + 4'h1;
                log_cnt_r <= (log_cnt_r == 4'(LOG_DEPTH)) ? log_cnt_r : log_cnt_r + 4'h1;
                log_seq_r <= log_seq_r + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire
